/* hdl/numeric_error_reporting.sv */
// Numeric error reporting: error pin, ignore-error input and issue freeze
`timescale 1ns/1ps
//
// Overview of operation
// - Drive the error pin active when a floating-point instruction raises an error.
// - Errors whose class is masked in the unit's control word do not drive it.
// - Error pin is active low and stays driven during bus hold.
// - Ignore input asserted: keep issuing non-control FP instructions, pin still active.
// - Ignore input deasserted with error pending: freeze at next non-control FP instruction.
// - Native error mode bit set makes the ignore input have no effect.
// - Ignore input is asynchronous, active low, and is synchronised here.
// - In stop-grant or stop-clock, the pin holds its level from before entry.
//
module numeric_error_reporting (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire fp_err_pkg::fpu_event_s fpu_event,
  input  wire fp_err_pkg::issue_req_s issue_req,
  input  wire logic                   native_error_mode_bit,
  input  wire logic                   ignore_numeric_error_n,
  input  wire logic                   stop_grant,
  output logic                        fp_error_out_n,
  output logic                        issue_stall,
  output logic                        error_pending
);

  typedef struct packed {
    fp_err_pkg::err_state_e state;
    logic                   err_n;
    logic                   stall;
    logic                   pending;
  } nerr_s;

  nerr_s st_q;
  nerr_s st_d;
  logic  ignore_sync_n;
  logic  unmasked_err;
  logic  ignore_active;

  // Asynchronous ignore input goes through the three-stage filter
  pin_sync #(
    .STAGES    (fp_err_pkg::SYNC_STAGES),
    .RESET_VAL (fp_err_pkg::IGNORE_IDLE_N)
  ) u_ignore_sync (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .pin_in    (ignore_numeric_error_n),
    .level_out (ignore_sync_n)
  );

  // Only unmasked classes count as a reportable error
  assign unmasked_err = fpu_event.error_raise &&
                        |(fpu_event.class_flags & ~fpu_event.class_mask);
  // Native mode overrides the pin entirely
  assign ignore_active = !ignore_sync_n && !native_error_mode_bit;

  // Pending error state, freeze decision and pin level
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      fp_err_pkg::ST_IDLE: begin
        if (unmasked_err) begin
          st_d.state = fp_err_pkg::ST_PENDING;
        end
      end
      fp_err_pkg::ST_PENDING: begin
        // Clear loses to a new error in the same cycle so no event is dropped
        if (fpu_event.status_clear && !unmasked_err) begin
          st_d.state = fp_err_pkg::ST_IDLE;
        end else if (issue_req.fp_issue && !issue_req.fp_control && !ignore_active) begin
          st_d.state = fp_err_pkg::ST_FROZEN;
        end
      end
      fp_err_pkg::ST_FROZEN: begin
        // Ignore asserted late releases the freeze but keeps the error pending
        if (fpu_event.status_clear && !unmasked_err) begin
          st_d.state = fp_err_pkg::ST_IDLE;
        end else if (ignore_active) begin
          st_d.state = fp_err_pkg::ST_PENDING;
        end
      end
      default: begin
        st_d.state = fp_err_pkg::ST_IDLE;
      end
    endcase
    st_d.pending = (st_d.state != fp_err_pkg::ST_IDLE);
    // Stall is combinational-free: registered freeze state drives it
    st_d.stall   = (st_d.state == fp_err_pkg::ST_FROZEN);
    // Pin stays asserted while pending even when ignored; frozen level in stop-grant
    if (!stop_grant) begin
      st_d.err_n = !st_d.pending;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{state:   fp_err_pkg::ST_IDLE,
                err_n:   fp_err_pkg::FP_ERROR_IDLE_N,
                stall:   1'h0,
                pending: 1'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // Pin is always driven, never floated, so bus hold has no effect on it
  assign fp_error_out_n = st_q.err_n;
  assign issue_stall    = st_q.stall;
  assign error_pending  = st_q.pending;

endmodule

/* hdl/fp_err_pkg.sv */
// Package: shared types and constants for numeric error reporting
package fp_err_pkg;

  // Synchroniser depth for asynchronous pins
  localparam int unsigned SYNC_STAGES = 3;

  // Reset levels
  localparam logic FP_ERROR_IDLE_N = 1'h1;
  localparam logic IGNORE_IDLE_N   = 1'h1;

  // Floating-point status reported by the execution core
  typedef struct packed {
    logic       error_raise;   // Instruction finished with an exception
    logic [5:0] class_flags;   // Exception classes raised
    logic [5:0] class_mask;    // Masks from the unit's control word
    logic       status_clear;  // Software clears pending exception status
  } fpu_event_s;

  // Instruction issue request from the core
  typedef struct packed {
    logic fp_issue;      // Instruction about to issue is floating point
    logic fp_control;    // It is a control-class instruction
  } issue_req_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PENDING,
    ST_FROZEN
  } err_state_e;

endpackage

/* hdl/pin_sync.sv */
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned STAGES = fp_err_pkg::SYNC_STAGES,
  parameter logic        RESET_VAL = 1'h1
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_out
);

  initial begin
    if (STAGES < 3) begin
      $error("pin_sync needs at least three stages");
    end
  end

  typedef struct packed {
    logic [STAGES-1:0] chain;
    logic              level;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // Level moves only when the two last stages agree; first stage feeds only the second
  always_comb begin
    st_d       = st_q;
    st_d.chain = {st_q.chain[STAGES-2:0], pin_in};
    if (st_q.chain[STAGES-1] == st_q.chain[STAGES-2]) begin
      st_d.level = st_q.chain[STAGES-1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{chain: {STAGES{RESET_VAL}}, level: RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;

endmodule

/* dv/nerr_checker.sv */
// Port assertions for numeric error reporting
`timescale 1ns/1ps
module nerr_checker (
  input wire logic                   ref_clk,
  input wire logic                   rst_b,
  input wire fp_err_pkg::fpu_event_s fpu_event,
  input wire fp_err_pkg::issue_req_s issue_req,
  input wire logic                   native_error_mode_bit,
  input wire logic                   ignore_numeric_error_n,
  input wire logic                   stop_grant,
  input wire logic                   fp_error_out_n,
  input wire logic                   issue_stall,
  input wire logic                   error_pending
);
  // Unmasked error, and a clear that no new error overrides
  wire logic hit = fpu_event.error_raise & |(fpu_event.class_flags & ~fpu_event.class_mask);
  wire logic clr = fpu_event.status_clear & !hit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Outputs against their cause one edge earlier, except stall against pending at the same edge
  a_err_set: assert property (hit |=> error_pending) else $error("set");
  a_mask_quiet: assert property (!hit && !error_pending |=> !error_pending)
    else $error("mask");
  a_pin_level: assert property (!stop_grant |=> fp_error_out_n == !error_pending)
    else $error("pin");
  a_stop_hold: assert property (stop_grant |=> $stable(fp_error_out_n)) else $error("hold");
  a_clear_drop: assert property (clr |=> !error_pending) else $error("clear");
  a_pend_hold: assert property (error_pending && !clr |=> error_pending) else $error("pend");
  a_stall_pend: assert property (issue_stall |-> error_pending) else $error("idle");
  a_stall_clear: assert property (clr |=> !issue_stall) else $error("stall");
  // Native mode: a pending error freezes the next non-control instruction whatever the pin
  a_stall_set: assert property (error_pending && !issue_stall && !clr && native_error_mode_bit
    && issue_req.fp_issue && !issue_req.fp_control |=> issue_stall) else $error("freeze");
  cover property (hit);
  cover property (issue_stall);
  cover property (stop_grant && !fp_error_out_n);
endmodule

/* dv/chipset_model.sv */
// Chipset model answering the error pin on the ignore pin
`timescale 1ns/1ps
module chipset_model (
  input  wire logic       fp_error_out_n,
  input  wire logic [1:0] mode,
  output logic            ignore_numeric_error_n = 1'h1
);
  // Bit 0 enables, bit 1 slows; off any clock edge, released pin rests on its pull-up
  always @(fp_error_out_n or mode)
    ignore_numeric_error_n <= #(mode[1] ? 45 : 3) !(mode[0] && !fp_error_out_n);
endmodule

/* dv/tb.sv */
// Self-checking bench for numeric error reporting
`timescale 1ns/1ps
module tb;
  logic                   ref_clk = 1'h0, rst_b = 1'h0, stop_grant = 1'h0;
  logic                   native_error_mode_bit = 1'h1, ignore_numeric_error_n;
  logic                   fp_error_out_n, issue_stall, error_pending;
  logic [1:0]             mode = 2'h0;
  logic [2:0]             q[$];
  logic [31:0]            r = 32'h731e;
  fp_err_pkg::fpu_event_s fpu_event = '0;
  fp_err_pkg::issue_req_s issue_req = '0;
  int                     miscompares = 0, tests_run = 0;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  numeric_error_reporting i_numeric_error_reporting (.ref_clk, .rst_b, .fpu_event, .issue_req,
    .native_error_mode_bit, .ignore_numeric_error_n, .stop_grant, .fp_error_out_n,
    .issue_stall, .error_pending);
  chipset_model i_chipset_model (.fp_error_out_n, .mode, .ignore_numeric_error_n);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Drive at the falling edge; note is {pin, pending, stall}, bit 3 means no note
  task automatic ev(input logic [16:0] v, input logic [3:0] x);
    {fpu_event, issue_req, stop_grant} = v;
    r = lfsr(r);
    if (!x[3]) q.push_back(x[2:0]);
    @(negedge ref_clk);
  endtask
  // Oldest note against outputs settled after the edge that took the inputs; delay avoids a race
  always @(posedge ref_clk) begin
    #2;
    if (q.size() > 0) begin
      tests_run++;
      if ({fp_error_out_n, error_pending, issue_stall} !== q[0]) begin
        miscompares++;
        $display("[FAIL] %0t %h %h", $time, {fp_error_out_n, error_pending, issue_stall}, q[0]);
      end
      q.delete(0);
    end
  end
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Native mode first, then the ignore pin worked by the chipset model
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1'h1;
    ev({1'h1, r[5:0], 6'h3f, 4'h0}, 4'h4);
    ev({1'h1, r[5:0] | 6'h01, r[11:6] & 6'h3e, 4'h0}, 4'h2);
    ev(17'h6, 4'h2);
    ev(17'h9, 4'h0);
    ev(17'h0, 4'h4);
    ev(17'h10400, 4'h2);
    ev(17'h4, 4'h3);
    ev(17'h8, 4'h4);
    native_error_mode_bit = 1'h0;
    mode = 2'h1;
    ev(17'h10810, 4'h2);
    repeat (8) ev(17'h0, 4'h8);
    ev(17'h4, 4'h2);
    mode = 2'h0;
    repeat (8) ev(17'h0, 4'h8);
    ev(17'h4, 4'h3);
    mode = 2'h3;
    repeat (16) ev(17'h0, 4'h8);
    ev(17'h0, 4'h2);
    ev(17'h8, 4'h4);
    repeat (2) ev(17'h0, 4'h8);
    print_verdict();
  end
endmodule
bind numeric_error_reporting nerr_checker i_nerr_checker (.ref_clk, .rst_b, .fpu_event,
  .issue_req, .native_error_mode_bit, .ignore_numeric_error_n,
  .stop_grant, .fp_error_out_n, .issue_stall, .error_pending);
